// ==== logic/ces_sequencer.sv ====
// Function
// - Accept one nonmaskable pin, one break, sixteen external maskable requests.
// - Accept peripheral requests: 4 DMA, 26 pulse timer, 24 timer, 20 serial.
// - Every source has its own vector number and table offset.
// - Two control modes and eight levels; nonmaskable source ignores masking.
// - Push PC, condition and extended regs, update mask, clear trace, fetch vector.
// - Trap uses vector number field 0 to 3 from instruction.
// - Trap is never masked in program execution.
// - Trap sets I, keeps user bit; mode 2 clears trace, keeps level.
// - Sleep raises exception only with standby select 0 and enable 1.
// - Enabled sleep exception is never masked.
// - Sleep exception waits until CPU regains bus mastership.
// - Sleep sets I; mode 2 clears trace and sets level to 7.
// - Undefined opcode starts unmaskable general illegal exception.
// - Long or PC-changing slot instruction raises slot illegal exception.
// - Illegal sets I, keeps user bit; mode 2 clears trace, keeps level.
// - Stack accesses assume address bit zero is 0.
// - Stack use with odd stack pointer raises address error.
// - Mode 00 masks by I bit; 10 by level and priority; others prohibited.
// - In mode 2, trace bit set gives trace exception after each instruction.
//
// Purpose: Sequences exception entry for interrupts, traps, sleep and illegal codes
// Assumes: Core pulses instruction events one cycle; stack port always accepts
// Notes: Registers over AHB-Lite; zero wait states
`default_nettype none
module ces_sequencer
  import ces_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Sync reset, low
  input wire logic nmi_i, // Nonmaskable request pulse
  input wire logic brk_i, // Break request pulse
  input wire logic [CES_N_MASK-1:0] mreq_i, // Maskable request levels
  input wire logic [2:0] mlvl_i [CES_N_MASK], // Priority per source
  input wire logic trap_i, // Trap executed pulse
  input wire logic [1:0] trap_vec_i, // Trap vector field
  input wire logic sleep_i, // Sleep executed pulse
  input wire logic undef_i, // Undefined opcode pulse
  input wire logic slot_i, // Delay slot instruction pulse
  input wire logic slot_bad_i, // Slot op long or alters PC
  input wire logic insn_done_i, // Instruction completed pulse
  input wire logic bus_other_i, // Other master owns bus
  input wire logic [31:0] pc_i, // Return PC from core
  input wire logic [31:0] vec_data_i, // Vector read data
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hsel_i, // AHB select
  input wire logic hready_i, // AHB ready in
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB ready out
  output logic hresp_o, // AHB response
  output ces_stack_type stack_o, // Stack write
  output logic [31:0] vec_addr_o, // Vector table address
  output logic vec_rd_o, // Vector read strobe
  output logic [31:0] new_pc_o, // Handler start address
  output logic pc_load_o, // Load PC pulse
  output logic busy_o, // Exception entry in progress
  output logic [CES_N_MASK-1:0] mack_o // Maskable accept pulse
);

  ces_state_type state_q;
  ces_kind_type kind_q;
  ces_kind_type kind_d;
  logic [7:0] vec_q;
  logic [7:0] vec_d;
  logic [1:0] mode_q;
  logic [7:0] stby_q;
  logic [7:0] ccr_q;
  logic [7:0] exr_q;
  logic [31:0] sp_q;
  logic [31:0] pc_q;
  logic sleep_pend_q;
  logic adr_active_q;
  logic [2:0] acc_lvl_q;
  logic [2:0] acc_lvl_d;
  logic [CES_N_MASK-1:0] acc_vec_d;
  logic [7:0] stat_q;
  logic take;
  logic sp_odd;
  logic m_hit;
  logic [6:0] m_idx;

  // ****************************************
  // Maskable arbitration
  // ****************************************

  // True when a maskable request at this level passes the mask
  function automatic logic ces_pass(input logic [1:0] mode, input logic [7:0] condition_code_reg,
                                    input logic [7:0] extended_control_reg, input logic [2:0] lvl);
    logic r;
    r = 1'b0;
    if (mode == CES_MODE_0) begin
      r = !condition_code_reg[CES_CCR_I_POS];
    end else if (mode == CES_MODE_2) begin
      r = (lvl > extended_control_reg[2:0]);
    end
    return r;
  endfunction

  // Highest level wins, lowest index breaks ties
  always_comb begin
    m_hit = 1'b0;
    m_idx = 7'h00;
    acc_lvl_d = 3'h0;
    for (int k = 0; k < CES_N_MASK; k++) begin
      if (mreq_i[k] && ces_pass(mode_q, ccr_q, exr_q, mlvl_i[k]) &&
          (!m_hit || mlvl_i[k] > acc_lvl_d)) begin
        m_hit = 1'b1;
        m_idx = 7'(k);
        acc_lvl_d = mlvl_i[k];
      end
    end
  end

  // ****************************************
  // Source selection
  // ****************************************
  assign sp_odd = sp_q[0];

  // Unmaskable sources first, then trace, then maskable
  always_comb begin
    kind_d = CES_K_NONE;
    vec_d = 8'h00;
    acc_vec_d = '0;
    if (adr_active_q) begin
      kind_d = CES_K_ADR;
      vec_d = CES_VEC_ADRERR;
    end else if (nmi_i) begin
      kind_d = CES_K_NMI;
      vec_d = CES_VEC_NMI;
    end else if (trap_i) begin
      kind_d = CES_K_TRAP;
      vec_d = CES_VEC_TRAP0 + {6'h00, trap_vec_i};
    end else if (undef_i) begin
      kind_d = CES_K_ILL;
      vec_d = CES_VEC_ILL;
    end else if (slot_i && slot_bad_i) begin
      kind_d = CES_K_SLOT;
      vec_d = CES_VEC_SLOT;
    end else if (sleep_pend_q && !bus_other_i) begin
      kind_d = CES_K_SLEEP;
      vec_d = CES_VEC_SLEEP;
    end else if (brk_i) begin
      kind_d = CES_K_BRK;
      vec_d = CES_VEC_BRK;
    end else if (insn_done_i && exr_q[CES_EXR_T_POS] && mode_q == CES_MODE_2) begin
      kind_d = CES_K_TRACE;
      vec_d = CES_VEC_TRACE;
    end else if (m_hit) begin
      kind_d = CES_K_IRQ;
      vec_d = CES_VEC_IRQ0 + {1'b0, m_idx};
      acc_vec_d[m_idx] = 1'b1;
    end
  end

  assign take = (state_q == CES_S_RUN) && (kind_d != CES_K_NONE);
  assign mack_o = take ? acc_vec_d : '0;
  assign busy_o = (state_q != CES_S_RUN);

  // Sleep event held until taken
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sleep_pend_q <= 1'b0;
    end else if (sleep_i && !stby_q[CES_STBY_SOFTWARE_STANDBY_SELECT_POS] && stby_q[CES_STBY_SLEEP_EXCEPTION_ENABLE_POS]) begin
      sleep_pend_q <= 1'b1;
    end else if (take && kind_d == CES_K_SLEEP) begin
      sleep_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Entry sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= CES_S_RUN;
      kind_q <= CES_K_NONE;
      vec_q <= 8'h00;
      acc_lvl_q <= 3'h0;
      pc_q <= 32'h0000_0000;
      adr_active_q <= 1'b0;
    end else begin
      unique case (state_q)
        CES_S_RUN: begin
          if (take) begin
            kind_q <= kind_d;
            vec_q <= vec_d;
            acc_lvl_q <= acc_lvl_d;
            pc_q <= pc_i;
            state_q <= sp_odd ? CES_S_FETCH : CES_S_PUSH_PC;
            if (sp_odd && kind_d != CES_K_ADR) begin
              adr_active_q <= 1'b1;
            end else if (kind_d == CES_K_ADR) begin
              adr_active_q <= 1'b0;
            end
          end
        end
        CES_S_PUSH_PC: state_q <= CES_S_PUSH_FL;
        CES_S_PUSH_FL: state_q <= CES_S_FETCH;
        CES_S_FETCH: state_q <= CES_S_WAIT_BUS;
        CES_S_WAIT_BUS: state_q <= CES_S_RUN;
      endcase
    end
  end

  // Odd stack pointer stacking skipped, the source's own vector is fetched, then an address error entry follows
  always_comb begin
    stack_o = '0;
    if (state_q == CES_S_PUSH_PC) begin
      stack_o.valid = 1'b1;
      stack_o.addr = {sp_q[31:1], 1'b0} - 32'h0000_0004;
      stack_o.data = pc_q;
    end else if (state_q == CES_S_PUSH_FL) begin
      stack_o.valid = 1'b1;
      stack_o.addr = {sp_q[31:1], 1'b0} - 32'h0000_0002;
      stack_o.data = {16'h0000, ccr_q, exr_q};
    end
  end

  assign vec_rd_o = (state_q == CES_S_FETCH);
  assign vec_addr_o = 32'({vec_q}) * CES_VEC_SCALE;

  // Handler address latched from the table read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      new_pc_o <= 32'h0000_0000;
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= (state_q == CES_S_FETCH);
      if (state_q == CES_S_FETCH) begin
        new_pc_o <= vec_data_i;
      end
    end
  end

  // ****************************************
  // Mask update on entry
  // ****************************************
  logic bus_wr_q;
  logic [7:0] bus_addr_q;
  logic bus_rd_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ccr_q <= CES_CCR_RST;
      exr_q <= CES_EXR_RST;
    end else if (state_q == CES_S_PUSH_FL || (state_q == CES_S_FETCH && kind_q == CES_K_ADR)) begin
      ccr_q[CES_CCR_I_POS] <= 1'b1;
      if (mode_q == CES_MODE_2) begin
        exr_q[CES_EXR_T_POS] <= 1'b0;
        if (kind_q == CES_K_SLEEP || kind_q == CES_K_ADR) begin
          exr_q[2:0] <= CES_LVL_MAX;
        end else if (kind_q == CES_K_IRQ) begin
          exr_q[2:0] <= acc_lvl_q;
        end else if (kind_q == CES_K_NMI) begin
          exr_q[2:0] <= CES_LVL_MAX;
        end
      end
    end else if (bus_wr_q && bus_addr_q == CES_OFF_CCR) begin
      ccr_q <= hwdata_i[7:0];
    end else if (bus_wr_q && bus_addr_q == CES_OFF_EXR) begin
      exr_q <= hwdata_i[7:0];
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_wr_q <= 1'b0;
      bus_rd_q <= 1'b0;
      bus_addr_q <= 8'h00;
    end else begin
      bus_wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      bus_rd_q <= hsel_i && hready_i && htrans_i[1] && !hwrite_i;
      if (hsel_i && hready_i && htrans_i[1]) begin
        bus_addr_q <= haddr_i[7:0];
      end
    end
  end

  // Control, standby and stack pointer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_q <= CES_MODE_RST;
      stby_q <= CES_STBY_RST;
      sp_q <= CES_SP_RST;
    end else begin
      if (bus_wr_q && bus_addr_q == CES_OFF_CTRL && hwdata_i[1:0] != 2'h1 &&
          hwdata_i[1:0] != 2'h3) begin
        mode_q <= hwdata_i[1:0];
      end
      if (bus_wr_q && bus_addr_q == CES_OFF_STBY) begin
        stby_q <= hwdata_i[7:0];
      end
      if (state_q == CES_S_PUSH_FL) begin
        sp_q <= sp_q - 32'h0000_0004;
      end else if (bus_wr_q && bus_addr_q == CES_OFF_SP) begin
        sp_q <= hwdata_i;
      end
    end
  end

  // Status: last kind, vector, address error pending
  always_comb begin
    stat_q = {3'h0, adr_active_q, kind_q};
  end

  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (bus_rd_q) begin
      unique case (bus_addr_q)
        CES_OFF_CTRL: hrdata_o = {30'h0000_0000, mode_q};
        CES_OFF_STBY: hrdata_o = {24'h00_0000, stby_q};
        CES_OFF_CCR: hrdata_o = {24'h00_0000, ccr_q};
        CES_OFF_EXR: hrdata_o = {24'h00_0000, exr_q};
        CES_OFF_SP: hrdata_o = sp_q;
        CES_OFF_STAT: hrdata_o = {16'h0000, vec_q, stat_q};
        CES_OFF_PC: hrdata_o = new_pc_o;
        default: hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ****************************************
  // Checks
  // ****************************************
  property p_trap_enter;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CES_S_RUN && trap_i && !nmi_i && !adr_active_q && !sp_odd)
      |=> state_q == CES_S_PUSH_PC;
  endproperty
  a_trap_enter: assert property (p_trap_enter) else $error("trap not entered");

  property p_seq;
    @(posedge clk_i) disable iff (!rst_n_i)
      state_q == CES_S_PUSH_PC |=> state_q == CES_S_PUSH_FL ##1 state_q == CES_S_FETCH
      ##1 pc_load_o;
  endproperty
  a_seq: assert property (p_seq) else $error("entry order wrong");

  property p_imask;
    @(posedge clk_i) disable iff (!rst_n_i)
      state_q == CES_S_PUSH_FL |=> ccr_q[CES_CCR_I_POS];
  endproperty
  a_imask: assert property (p_imask) else $error("mask bit not set");

  property p_sleep_lvl;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CES_S_PUSH_FL && kind_q == CES_K_SLEEP && mode_q == CES_MODE_2)
      |=> exr_q[2:0] == 3'h7 && !exr_q[CES_EXR_T_POS];
  endproperty
  a_sleep_lvl: assert property (p_sleep_lvl) else $error("sleep level wrong");

  property p_trap_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CES_S_PUSH_FL && kind_q == CES_K_TRAP)
      |=> exr_q[2:0] == $past(exr_q[2:0]) && ccr_q[CES_CCR_UI_POS] == $past(ccr_q[6]);
  endproperty
  a_trap_keep: assert property (p_trap_keep) else $error("trap changed level");

  property p_sleep_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      bus_other_i |-> !(take && kind_d == CES_K_SLEEP);
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("sleep during other master");

  property p_stack_even;
    @(posedge clk_i) disable iff (!rst_n_i)
      stack_o.valid |-> !stack_o.addr[0] && !sp_q[0];
  endproperty
  a_stack_even: assert property (p_stack_even) else $error("odd stack address");

  property p_odd_sp;
    @(posedge clk_i) disable iff (!rst_n_i)
      (take && sp_odd && kind_d != CES_K_ADR) |=> adr_active_q && state_q == CES_S_FETCH;
  endproperty
  a_odd_sp: assert property (p_odd_sp) else $error("odd stack not caught");

  property p_mode_legal;
    @(posedge clk_i) disable iff (!rst_n_i)
      mode_q == CES_MODE_0 || mode_q == CES_MODE_2;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("prohibited mode");

endmodule
`default_nettype wire

// ==== logic/ces_pkg.sv ====
// Purpose: Shared constants and types for the exception sequencer
// Assumes: 250 MHz system clock, synchronous active-low reset
// Notes: Vector numbers are fixed constants; the sequencer scales them by 4 into table offsets
`default_nettype none
package ces_pkg;
  // ****************************************
  // Register offsets (AHB-Lite byte addresses)
  // ****************************************
  localparam logic [7:0] CES_OFF_CTRL = 8'h00;
  localparam logic [7:0] CES_OFF_STBY = 8'h04;
  localparam logic [7:0] CES_OFF_CCR = 8'h08;
  localparam logic [7:0] CES_OFF_EXR = 8'h0C;
  localparam logic [7:0] CES_OFF_SP = 8'h10;
  localparam logic [7:0] CES_OFF_STAT = 8'h14;
  localparam logic [7:0] CES_OFF_PC = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CES_CCR_I_POS = 7;
  localparam int CES_CCR_UI_POS = 6;
  localparam int CES_EXR_T_POS = 7;
  localparam int CES_STBY_SOFTWARE_STANDBY_SELECT_POS = 7;
  localparam int CES_STBY_SLEEP_EXCEPTION_ENABLE_POS = 0;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] CES_CCR_RST = 8'h80;
  localparam logic [7:0] CES_EXR_RST = 8'h07;
  localparam logic [7:0] CES_STBY_RST = 8'h00;
  localparam logic [1:0] CES_MODE_RST = 2'h0;
  localparam logic [1:0] CES_MODE_0 = 2'h0;
  localparam logic [1:0] CES_MODE_2 = 2'h2;
  localparam logic [2:0] CES_LVL_MAX = 3'h7;
  localparam logic [31:0] CES_SP_RST = 32'h0000_0000;

  // ****************************************
  // Source counts
  // ****************************************
  localparam int CES_N_EXT = 16;
  localparam int CES_N_DMA = 4;
  localparam int CES_N_PTU = 26;
  localparam int CES_N_TMR = 24;
  localparam int CES_N_SCI = 20;
  localparam int CES_N_MISC = 5;
  localparam int CES_N_MASK = CES_N_EXT + CES_N_DMA + CES_N_PTU + CES_N_TMR + CES_N_SCI
                              + CES_N_MISC;

  // ****************************************
  // Vector numbers
  // ****************************************
  localparam logic [7:0] CES_VEC_NMI = 8'h07;
  localparam logic [7:0] CES_VEC_TRAP0 = 8'h08;
  localparam logic [7:0] CES_VEC_SLEEP = 8'h0C;
  localparam logic [7:0] CES_VEC_BRK = 8'h0E;
  localparam logic [7:0] CES_VEC_ILL = 8'h0F;
  localparam logic [7:0] CES_VEC_SLOT = 8'h10;
  localparam logic [7:0] CES_VEC_ADRERR = 8'h11;
  localparam logic [7:0] CES_VEC_IRQ0 = 8'h40;
  localparam logic [7:0] CES_VEC_TRACE = 8'h05;
  localparam logic [31:0] CES_VEC_SCALE = 32'h0000_0004;

  typedef enum logic [3:0] {
    CES_K_NONE = 4'h0, CES_K_NMI = 4'h1, CES_K_BRK = 4'h2, CES_K_IRQ = 4'h3,
    CES_K_TRAP = 4'h4, CES_K_SLEEP = 4'h5, CES_K_ILL = 4'h6, CES_K_SLOT = 4'h7,
    CES_K_ADR = 4'h8, CES_K_TRACE = 4'h9
  } ces_kind_type;

  typedef enum logic [2:0] {
    CES_S_RUN = 3'h0, CES_S_PUSH_PC = 3'h1, CES_S_PUSH_FL = 3'h2,
    CES_S_FETCH = 3'h3, CES_S_WAIT_BUS = 3'h4
  } ces_state_type;

  // Stack write request to the core memory
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } ces_stack_type;
endpackage
`default_nettype wire

// ==== sim/ces_irq_model.sv ====
// Purpose: Interrupt controller, vector table and other bus master model
// Assumes: A request stands until the sequencer accepts it
// Notes: Vector word is handler base plus vector address
`default_nettype none
module ces_irq_model
  import ces_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Sync reset, low
  input wire logic post_i, // Raise one request
  input wire logic [6:0] post_idx_i, // Source index
  input wire logic [2:0] post_lvl_i, // Its priority
  input wire logic hold_i, // Other master wants the bus
  input wire logic [CES_N_MASK-1:0] mack_i, // Accept pulses
  input wire logic vec_rd_i, // Vector read strobe
  input wire logic [31:0] vec_addr_i, // Vector address
  output logic [CES_N_MASK-1:0] mreq_o, // Request levels
  output logic [2:0] mlvl_o [CES_N_MASK], // Priority per source
  output logic bus_other_o, // Bus owned elsewhere
  output logic [31:0] vec_data_o // Vector word
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Requests
  // ****************************************
  // Each source stands on its own line until accepted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mreq_o <= '0;
      for (int i = 0; i < CES_N_MASK; i++) begin
        mlvl_o[i] <= 3'h0;
      end
    end else begin
      mreq_o <= (mreq_o & ~mack_i) | (CES_N_MASK'(post_i) << post_idx_i);
      if (post_i) begin
        mlvl_o[post_idx_i] <= post_lvl_i;
      end
    end
  end

  // Other master keeps the bus while asked
  assign bus_other_o = hold_i;

  // Own handler per vector; inverse shown when not read
  assign vec_data_o = vec_rd_i ? 32'h0001_0000 + vec_addr_i : ~(32'h0001_0000 + vec_addr_i);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Zero-wait register bus, vector table in the model
// Notes: Entries are judged at the vector, stack and register ports
`default_nettype none
module testbench
  import ces_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic nmi = 1'h0, brk = 1'h0, trap = 1'h0, sleep = 1'h0, undef = 1'h0, slot = 1'h0;
  logic slot_bad = 1'h0, done = 1'h0, hold = 1'h0, post = 1'h0, hwrite = 1'h0, hsel = 1'h0;
  logic [1:0] tvec = 2'h0, htrans = 2'h0;
  logic [6:0] pidx = 7'h00;
  logic [2:0] plvl = 3'h0, hsize = 3'h2;
  logic [31:0] pc = 32'h0000_2468, haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata, vec_data, vec_addr, new_pc, last_va, last_pc, sa0, sa1, sd0, sd1, rd, sp;
  logic hreadyout, hresp, vec_rd, pc_load, busy, bus_other;
  logic odd_push = 1'h0;
  logic [CES_N_MASK-1:0] mreq, mack;
  logic [2:0] mlvl [CES_N_MASK];
  ces_stack_type stk;
  int entries = 0, num_errors = 0, check_count = 0;
  logic [7:0] kvec [4] = '{CES_VEC_NMI, CES_VEC_BRK, CES_VEC_ILL, CES_VEC_SLOT};
  logic [7:0] m2_in [4] = '{8'h85, 8'h82, 8'h83, 8'h81};
  logic [7:0] m2_out [4] = '{8'h05, 8'h07, 8'h03, 8'h01};
  logic [7:0] m2_v [4] = '{CES_VEC_TRAP0 + 8'h03, CES_VEC_SLEEP, CES_VEC_ILL, CES_VEC_TRACE};
  int m2_k [4] = '{4, 5, 2, 6};

  // Clock
  always #2 clk_i = ~clk_i;

  ces_sequencer i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .nmi_i(nmi), .brk_i(brk), .mreq_i(mreq),
    .mlvl_i(mlvl), .trap_i(trap), .trap_vec_i(tvec), .sleep_i(sleep), .undef_i(undef),
    .slot_i(slot), .slot_bad_i(slot_bad), .insn_done_i(done), .bus_other_i(bus_other),
    .pc_i(pc), .vec_data_i(vec_data), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .stack_o(stk),
    .vec_addr_o(vec_addr), .vec_rd_o(vec_rd), .new_pc_o(new_pc), .pc_load_o(pc_load),
    .busy_o(busy), .mack_o(mack)
  );

  ces_irq_model i_irq (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .post_i(post), .post_idx_i(pidx), .post_lvl_i(plvl),
    .hold_i(hold), .mack_i(mack), .vec_rd_i(vec_rd), .vec_addr_i(vec_addr), .mreq_o(mreq),
    .mlvl_o(mlvl), .bus_other_o(bus_other), .vec_data_o(vec_data)
  );

  // ****************************************
  // Monitor and helpers
  // ****************************************
  // Record vector, handler and stack writes of each entry
  always @(posedge clk_i) begin
    if (vec_rd) last_va <= vec_addr;
    if (pc_load) begin
      entries <= entries + 1;
      last_pc <= new_pc;
    end
    if (stk.valid === 1'h1) begin
      sa1 <= sa0;
      sa0 <= stk.addr;
      sd1 <= sd0;
      sd0 <= stk.data;
      odd_push <= odd_push | stk.addr[0];
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (hreadyout !== 1'h1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask

  // One-cycle pulse on a core event line or the model's post line
  task automatic fire(input int k);
    @(posedge clk_i);
    case (k)
      0: nmi <= 1'h1;
      1: brk <= 1'h1;
      2: undef <= 1'h1;
      3: slot <= 1'h1;
      4: trap <= 1'h1;
      5: sleep <= 1'h1;
      6: done <= 1'h1;
      default: post <= 1'h1;
    endcase
    @(posedge clk_i);
    {nmi, brk, undef, slot, trap, sleep, done, post} <= 8'h00;
  endtask

  // Waits out an entry; vec below zero skips the vector compare
  task automatic expect_entry(input logic exp, input int vec);
    int n0;
    int n;
    n0 = entries;
    for (n = 0; n < 16 && entries == n0; n++) @(posedge clk_i);
    for (n = 0; n < 16 && busy !== 1'h0; n++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    for (n = 0; n < 16 && busy !== 1'h0; n++) @(posedge clk_i);
    @(posedge clk_i);
    check(32'(busy), 32'h0);
    check(32'(entries != n0), 32'(exp));
    if (exp && vec >= 0) begin
      check(last_va, 32'(vec) << 2);
      check(last_pc, 32'h0001_0000 + (32'(vec) << 2));
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rdc(CES_OFF_CTRL, 32'(CES_MODE_RST));
    rdc(CES_OFF_CCR, 32'(CES_CCR_RST));
    rdc(32'h0000_0040, 32'h0);
    wr(CES_OFF_SP, 32'h0000_1000);
    wr(CES_OFF_CCR, 32'h0000_0040);
    sp = 32'h0000_1000;
    for (int v = 0; v < 4; v++) begin
      tvec <= 2'(v);
      fire(4);
      expect_entry(1'h1, CES_VEC_TRAP0 + v);
      check(sa1, sp - 32'h4);
      check(sd1, pc);
      check(sa0, sp - 32'h2);
      sp = sp - 32'h4;
    end
    rdc(CES_OFF_SP, sp);
    rdc(CES_OFF_CCR, 32'h0000_00C0);
    rdc(CES_OFF_EXR, 32'(CES_EXR_RST));
    slot_bad <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      fire(k);
      expect_entry(1'h1, kvec[k]);
    end
    slot_bad <= 1'h0;
    fire(3);
    expect_entry(1'h0, 0);
    // Maskable source in mode 0, masked then released by the I bit
    plvl <= 3'h1;
    fire(7);
    expect_entry(1'h0, 0);
    wr(CES_OFF_CCR, 32'h0);
    expect_entry(1'h1, CES_VEC_IRQ0);
    rdc(CES_OFF_CCR, 32'h0000_0080);
    // Sleep: standby selected, then enabled but bus held elsewhere
    wr(CES_OFF_STBY, 32'h0000_0081);
    fire(5);
    expect_entry(1'h0, 0);
    wr(CES_OFF_STBY, 32'h0000_0001);
    hold <= 1'h1;
    fire(5);
    expect_entry(1'h0, 0);
    hold <= 1'h0;
    expect_entry(1'h1, CES_VEC_SLEEP);
    wr(CES_OFF_EXR, 32'h0000_0080);
    fire(6);
    expect_entry(1'h0, 0);
    wr(CES_OFF_CTRL, 32'h1);
    rdc(CES_OFF_CTRL, 32'h0);
    wr(CES_OFF_CTRL, 32'h2);
    rdc(CES_OFF_CTRL, 32'h2);
    // Mode 2 flag effects of trap, sleep, illegal and trace
    for (int j = 0; j < 4; j++) begin
      wr(CES_OFF_EXR, 32'(m2_in[j]));
      fire(m2_k[j]);
      expect_entry(1'h1, m2_v[j]);
      rdc(CES_OFF_EXR, 32'(m2_out[j]));
    end
    // Level masking in mode 2
    wr(CES_OFF_EXR, 32'h6);
    plvl <= 3'h4;
    fire(7);
    expect_entry(1'h0, 0);
    wr(CES_OFF_EXR, 32'h3);
    expect_entry(1'h1, CES_VEC_IRQ0);
    rdc(CES_OFF_EXR, 32'h4);
    pidx <= 7'h14;
    plvl <= 3'h6;
    fire(7);
    expect_entry(1'h1, CES_VEC_IRQ0 + 20);
    check(32'(last_va === 32'(CES_VEC_IRQ0) << 2), 32'h0);
    rdc(CES_OFF_EXR, 32'h6);
    // Odd stack pointer
    wr(CES_OFF_SP, 32'h0000_0801);
    fire(4);
    expect_entry(1'h1, CES_VEC_ADRERR);
    check(32'(odd_push), 32'h0);
    rdc(CES_OFF_PC, 32'h0001_0000 + (32'(CES_VEC_ADRERR) << 2));
    tally_and_finish();
  end
endmodule
`default_nettype wire
